// >>> pkg/teia_pkg.sv
// Purpose: Constants for the time engine indirect access window
// Assumes: 16-bit registers at word offsets
// Notes: Destination and source codes match the command fields
package teia_pkg;
  localparam logic [3:0] ADDR_HDR1 = 4'h7;
  localparam logic [3:0] ADDR_HDR2 = 4'h8;
  localparam logic [3:0] ADDR_WIN1 = 4'h9;
  localparam logic [3:0] ADDR_WIN2 = 4'ha;
  localparam logic [3:0] ADDR_WIN3 = 4'hb;
  localparam logic [3:0] ADDR_WIN4 = 4'hc;
  localparam logic [3:0] ADDR_WIN5 = 4'hd;
  localparam logic [3:0] ADDR_CMD = 4'he;
  localparam int CMD_RD_BIT = 15;
  localparam int CMD_WR_BIT = 7;
  localparam int FETCH_LSB = 8;
  localparam int STORE_LSB = 0;
  localparam logic [15:0] CMD_RW_MASK = 16'h8780;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [2:0] FETCH_TIME = 3'h0;
  localparam logic [2:0] FETCH_Q1 = 3'h1;
  localparam logic [2:0] FETCH_Q2 = 3'h2;
  localparam logic [2:0] FETCH_Q3 = 3'h3;
  localparam logic [3:0] STORE_TIME = 4'h0;
  localparam logic [3:0] STORE_PERIOD = 4'h1;
  localparam logic [3:0] STORE_TWEAK = 4'h2;
  localparam logic [3:0] STORE_PG1 = 4'h3;
  localparam logic [3:0] STORE_PG2 = 4'h4;
  localparam logic [3:0] STORE_LATENCY = 4'h8;
  localparam logic [3:0] STORE_COR1 = 4'h9;
  localparam logic [3:0] STORE_COR2 = 4'ha;
  localparam logic [3:0] STORE_COR3 = 4'hb;
  localparam int CMD_DONE_CYCLES = 2;
endpackage : teia_pkg

// >>> verilog/teia_window.sv
// Purpose: Indirect-access window between management registers and time engine
// Assumes: Register port is a simple 16-bit strobe port on the device clock
// Notes: Stamp entries carry 48b sec, 30b ns, edge, kind, hash, order number
`timescale 1ns/1ps
module teia_window (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [47:0] now_sec,
  input wire logic [29:0] now_ns,
  input wire logic [2:0] queue_not_empty,
  input wire logic [47:0] queue_sec [3],
  input wire logic [29:0] queue_ns [3],
  input wire logic [2:0] queue_edge,
  input wire logic [3:0] queue_message_kind [3],
  input wire logic [11:0] queue_source_identity_hash [3],
  input wire logic [15:0] queue_packet_order_number [3],
  input wire logic queue_two_source_choice,
  input wire logic queue_three_source_choice,
  output logic [2:0] queue_pop,
  output logic time_load,
  output logic [47:0] time_sec,
  output logic [29:0] time_ns,
  output logic period_load,
  output logic tweak_load,
  output logic [7:0] period_ns,
  output logic [31:0] period_frac,
  output logic [23:0] tweak_duration,
  output logic [1:0] pulse_cmd_push,
  output logic [21:0] pulse_cmd,
  output logic [3:0] offset_load,
  output logic [29:0] offset_ns,
  output logic [1:0] offset_frac
);
  import teia_pkg::*;

  typedef enum logic [1:0] {TEIA_IDLE, TEIA_STORE, TEIA_FETCH} teia_state_t;
  teia_state_t state;
  logic [15:0] win [5];
  logic [15:0] hdr1;
  logic [15:0] hdr2;
  logic cmd_rd;
  logic cmd_wr;
  logic [2:0] fetch_sel;
  logic [3:0] store_sel;
  logic cmd_write;
  logic do_store;
  logic do_fetch;
  logic [1:0] qi;
  logic packet_q;
  // Local copy so the completion window bound is a plain constant here
  localparam int DONE_CYC = CMD_DONE_CYCLES;

  function automatic logic is_win(input logic [3:0] a);
    return (a >= ADDR_WIN1) && (a <= ADDR_WIN5);
  endfunction : is_win

  assign cmd_write = reg_wr && (reg_addr == ADDR_CMD);
  assign do_store = (state == TEIA_STORE);
  assign do_fetch = (state == TEIA_FETCH);
  assign qi = 2'(fetch_sel - FETCH_Q1);
  // Only queues two and three can hold packet stamps
  assign packet_q = ((fetch_sel == FETCH_Q2) && !queue_two_source_choice) ||
                    ((fetch_sel == FETCH_Q3) && !queue_three_source_choice);

  // ==========================================================
  // Register read decode
  always_comb begin
    reg_rdata = REG_RESET;
    if (reg_addr == ADDR_HDR1) begin
      reg_rdata = hdr1;
    end else if (reg_addr == ADDR_HDR2) begin
      reg_rdata = hdr2;
    end else if (is_win(reg_addr)) begin
      reg_rdata = win[3'(reg_addr - ADDR_WIN1)];
    end else if (reg_addr == ADDR_CMD) begin
      reg_rdata = {cmd_rd, 4'h0, fetch_sel, cmd_wr, 3'h0, store_sel};
    end
  end

  // ==========================================================
  // Command register and sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_rd <= 1'b0;
      cmd_wr <= 1'b0;
      fetch_sel <= 3'h0;
      store_sel <= 4'h0;
      state <= TEIA_IDLE;
    end else begin
      case (state)
        TEIA_IDLE: begin
          if (cmd_write) begin
            cmd_rd <= reg_wdata[CMD_RD_BIT];
            cmd_wr <= reg_wdata[CMD_WR_BIT];
            fetch_sel <= reg_wdata[FETCH_LSB +: 3];
            store_sel <= reg_wdata[STORE_LSB +: 4];
            if (reg_wdata[CMD_WR_BIT]) begin
              state <= TEIA_STORE;
            end else if (reg_wdata[CMD_RD_BIT]) begin
              state <= TEIA_FETCH;
            end
          end
        end
        TEIA_STORE: begin
          cmd_wr <= 1'b0;
          state <= cmd_rd ? TEIA_FETCH : TEIA_IDLE;
        end
        TEIA_FETCH: begin
          cmd_rd <= 1'b0;
          state <= TEIA_IDLE;
        end
        default: state <= TEIA_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Window words: software writes, fetch overwrites
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 5; i++) begin
        win[i] <= REG_RESET;
      end
    end else if (do_fetch && fetch_sel == FETCH_TIME) begin
      win[0] <= now_sec[15:0];
      win[1] <= now_sec[31:16];
      win[2] <= now_sec[47:32];
      win[3] <= now_ns[15:0];
      win[4] <= {2'b00, now_ns[29:16]};
    end else if (do_fetch && fetch_sel <= FETCH_Q3) begin
      win[0] <= queue_sec[qi][15:0];
      win[1] <= queue_sec[qi][31:16];
      win[2] <= queue_sec[qi][47:32];
      win[3] <= queue_ns[qi][15:0];
      win[4] <= {queue_edge[qi], 1'b0, queue_ns[qi][29:16]};
    end else if (reg_wr && is_win(reg_addr) && state == TEIA_IDLE) begin
      // Writes during a transfer are dropped; each store or fetch step is one cycle
      win[3'(reg_addr - ADDR_WIN1)] <= reg_wdata;
    end
  end

  // ==========================================================
  // Header capture words, packet queues only; edge reads leave them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hdr1 <= REG_RESET;
      hdr2 <= REG_RESET;
    end else if (do_fetch && packet_q) begin
      hdr1 <= {queue_message_kind[qi], queue_source_identity_hash[qi]};
      hdr2 <= queue_packet_order_number[qi];
    end
  end

  // Pop an entry only when it was actually taken
  always_comb begin
    queue_pop = 3'h0;
    if (do_fetch && fetch_sel >= FETCH_Q1 && fetch_sel <= FETCH_Q3) begin
      queue_pop[qi] = queue_not_empty[qi];
    end
  end

  // ==========================================================
  // Store strobes and destination fields
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      time_load <= 1'b0;
      period_load <= 1'b0;
      tweak_load <= 1'b0;
      pulse_cmd_push <= 2'h0;
      offset_load <= 4'h0;
      time_sec <= 48'h0;
      time_ns <= 30'h0;
      period_ns <= 8'h0;
      period_frac <= 32'h0;
      tweak_duration <= 24'h0;
      pulse_cmd <= 22'h0;
      offset_ns <= 30'h0;
      offset_frac <= 2'h0;
    end else begin
      time_load <= do_store && store_sel == STORE_TIME;
      period_load <= do_store && store_sel == STORE_PERIOD;
      tweak_load <= do_store && store_sel == STORE_TWEAK;
      pulse_cmd_push <= {do_store && store_sel == STORE_PG2,
                         do_store && store_sel == STORE_PG1};
      offset_load <= {do_store && store_sel == STORE_COR3,
                      do_store && store_sel == STORE_COR2,
                      do_store && store_sel == STORE_COR1,
                      do_store && store_sel == STORE_LATENCY};
      if (do_store) begin
        time_sec <= {win[2], win[1], win[0]};
        time_ns <= {win[4][13:0], win[3]};
        period_ns <= win[4][15:8];
        period_frac <= {win[4][7:0], win[3], win[2][15:8]};
        tweak_duration <= {win[2][7:0], win[1]};
        pulse_cmd <= {win[4][5:0], win[3]};
        offset_frac <= win[3][1:0];
        if (store_sel == STORE_LATENCY) begin
          offset_ns <= {1'b0, win[4][14:0], win[3][15:2]};
        end else begin
          offset_ns <= {win[4], win[3][15:2]};
        end
      end
    end
  end

  // ==========================================================
  // Checks
  a_store_then_fetch: assert property (@(posedge clk) disable iff (!nrst)
    do_store && cmd_rd |=> do_fetch)
    else $error("fetch did not follow store");
  a_cmd_clears: assert property (@(posedge clk) disable iff (!nrst)
    state == TEIA_IDLE && cmd_write && reg_wdata[CMD_WR_BIT] |->
    ##[1:DONE_CYC] !cmd_wr)
    else $error("write bit stuck");
  a_rd_clears: assert property (@(posedge clk) disable iff (!nrst)
    cmd_rd |-> ##[1:3] !cmd_rd)
    else $error("read bit stuck");
  a_time_word5: assert property (@(posedge clk) disable iff (!nrst)
    do_fetch && fetch_sel == FETCH_TIME |=> win[4][15:14] == 2'b00)
    else $error("time word five top bits set");
  a_edge_bit: assert property (@(posedge clk) disable iff (!nrst)
    do_fetch && fetch_sel == FETCH_Q1 |=>
    win[4][15] == $past(queue_edge[0]) && !win[4][14])
    else $error("edge bit wrong");
  a_hdr_seq: assert property (@(posedge clk) disable iff (!nrst)
    do_fetch && packet_q |=> hdr2 == $past(queue_packet_order_number[qi]))
    else $error("order number not captured");
  a_hdr_kind: assert property (@(posedge clk) disable iff (!nrst)
    do_fetch && packet_q |=> hdr1[15:12] == $past(queue_message_kind[qi]))
    else $error("message kind not captured");
  a_win_hold: assert property (@(posedge clk) disable iff (!nrst)
    !reg_wr && !do_fetch |=> $stable(win[0]))
    else $error("window word changed");
  a_pulse_fmt: assert property (@(posedge clk) disable iff (!nrst)
    do_store && store_sel == STORE_PG1 |=>
    pulse_cmd_push[0] && pulse_cmd[15:0] == $past(win[3]))
    else $error("pulse command wrong");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (!nrst)
    reg_addr == ADDR_CMD |-> (reg_rdata & ~16'h870f & ~CMD_RW_MASK) == 16'h0)
    else $error("reserved bits nonzero");
  a_hdr_hash: assert property (@(posedge clk) disable iff (!nrst)
    do_fetch && packet_q |=>
    hdr1[11:0] == $past(queue_source_identity_hash[qi]))
    else $error("identity hash not captured");
  a_hdr_keep: assert property (@(posedge clk) disable iff (!nrst)
    do_fetch && !packet_q |=> $stable(hdr1) && $stable(hdr2))
    else $error("header words changed on edge read");
  a_time_store: assert property (@(posedge clk) disable iff (!nrst)
    do_store && store_sel == STORE_TIME |=>
    time_load && time_sec == $past({win[2], win[1], win[0]}))
    else $error("time store wrong");
  a_period_fmt: assert property (@(posedge clk) disable iff (!nrst)
    do_store && store_sel == STORE_PERIOD |=>
    period_load && period_ns == $past(win[4][15:8]))
    else $error("period store wrong");
  a_tweak_fmt: assert property (@(posedge clk) disable iff (!nrst)
    do_store && store_sel == STORE_TWEAK |=>
    tweak_load && tweak_duration[15:0] == $past(win[1]))
    else $error("tweak count wrong");
  a_latency_fmt: assert property (@(posedge clk) disable iff (!nrst)
    do_store && store_sel == STORE_LATENCY |=> offset_load[0] && !offset_ns[29])
    else $error("latency store wrong");
  a_fetch_time: assert property (@(posedge clk) disable iff (!nrst)
    do_fetch && fetch_sel == FETCH_TIME |=>
    win[0] == $past(now_sec[15:0]) && win[3] == $past(now_ns[15:0]))
    else $error("time fetch wrong");
  a_fetch_q3: assert property (@(posedge clk) disable iff (!nrst)
    do_fetch && fetch_sel == FETCH_Q3 |=>
    win[2] == $past(queue_sec[2][47:32]))
    else $error("queue three fetch wrong");
  a_pop_idle: assert property (@(posedge clk) disable iff (!nrst)
    !do_fetch |-> queue_pop == 3'h0)
    else $error("queue popped outside fetch");

  // ==========================================================
  // Coverage of the main transfers
  c_both: cover property (@(posedge clk) do_store ##1 do_fetch);
  c_pkt: cover property (@(posedge clk) do_fetch && packet_q);
  c_time: cover property (@(posedge clk) do_store && store_sel == STORE_TIME);
  c_edge: cover property (@(posedge clk) do_fetch && !packet_q);
  c_latency: cover property (@(posedge clk)
    do_store && store_sel == STORE_LATENCY);
endmodule : teia_window

// >>> sim/teia_window_tb.sv
// Purpose: Self-checking bench for the time engine indirect access window
// Assumes: Inputs change on the falling edge; register reads are combinational
// Notes: Strobe pulses are counted on every falling edge and compared per op
`timescale 1ns/1ps
module tb;
  import teia_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic two_ch = 1'b0;
  logic three_ch = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic [15:0] reg_rdata, d, cw, h1o, h2o;
  logic [47:0] now_sec = 48'h0;
  logic [29:0] now_ns = 30'h0;
  logic [2:0] q_ne = 3'h0;
  logic [2:0] q_edge = 3'h0;
  logic [2:0] queue_pop;
  logic [47:0] q_sec [3], time_sec;
  logic [29:0] q_ns [3], time_ns, offset_ns;
  logic [3:0] q_kind [3], offset_load;
  logic [11:0] q_hash [3];
  logic [15:0] q_ord [3];
  logic [15:0] win [5];
  logic time_load, period_load, tweak_load;
  logic [7:0] period_ns;
  logic [31:0] period_frac;
  logic [23:0] tweak_duration;
  logic [1:0] pulse_cmd_push, offset_frac;
  logic [21:0] pulse_cmd;
  logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb};
  int cnt [14];
  int snap [14];
  int fail_count = 0;
  int total_checks = 0;
  wire logic [13:0] strb = {2'b00, queue_pop, offset_load, pulse_cmd_push,
    tweak_load, period_load, time_load};

  teia_window uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .now_sec(now_sec), .now_ns(now_ns),
    .queue_not_empty(q_ne), .queue_sec(q_sec), .queue_ns(q_ns),
    .queue_edge(q_edge), .queue_message_kind(q_kind),
    .queue_source_identity_hash(q_hash), .queue_packet_order_number(q_ord),
    .queue_two_source_choice(two_ch), .queue_three_source_choice(three_ch),
    .queue_pop(queue_pop), .time_load(time_load), .time_sec(time_sec),
    .time_ns(time_ns), .period_load(period_load), .tweak_load(tweak_load),
    .period_ns(period_ns), .period_frac(period_frac),
    .tweak_duration(tweak_duration), .pulse_cmd_push(pulse_cmd_push),
    .pulse_cmd(pulse_cmd), .offset_load(offset_load),
    .offset_ns(offset_ns), .offset_frac(offset_frac));

  // ====================================================================
  // Clock and strobe counting
  always #10 clk = ~clk;
  // Counted mid-cycle: pulses stand a full cycle, so no race with the edge
  always @(negedge clk) begin
    for (int i = 0; i < 14; i++) cnt[i] += int'(strb[i]);
  end

  // ====================================================================
  // Tasks
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task chk(input string n, input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [15:0] v);
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [15:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    #1 v = reg_rdata;
  endtask : rd

  task rnd;
    for (int i = 0; i < 5; i++) win[i] = 16'($urandom());
    now_sec = 48'({$urandom(), $urandom()});
    now_ns = 30'($urandom());
    for (int q = 0; q < 3; q++) begin
      q_sec[q] = 48'({$urandom(), $urandom()});
      q_ns[q] = 30'($urandom());
      q_kind[q] = 4'($urandom());
      q_hash[q] = 12'($urandom());
      q_ord[q] = 16'($urandom());
    end
    q_edge = 3'($urandom());
    two_ch = 1'($urandom());
    three_ch = 1'($urandom());
  endtask : rnd

  task load_win;
    for (int i = 0; i < 5; i++) wr(ADDR_WIN1 + 4'(i), win[i]);
  endtask : load_win

  // Window writes during a busy command are dropped, so always poll first
  task run(input logic [15:0] c, input logic [13:0] m);
    int i;
    rd(ADDR_HDR1, h1o);
    rd(ADDR_HDR2, h2o);
    snap = cnt;
    wr(ADDR_CMD, c);
    i = 0;
    do begin
      rd(ADDR_CMD, d);
      i++;
    end while ((d[15] | d[7]) && i < 8);
    if (d[15] | d[7]) begin
      fail_count++;
      $display("Error command busy expected 0 seen %h", d);
      summarize();
    end
    chk("command", d, c & 16'h070f);
    repeat (2) @(negedge clk);
    for (i = 0; i < 14; i++) chk("strobe", 64'(cnt[i] - snap[i]), 64'(m[i]));
  endtask : run

  task check_store(input logic [3:0] c);
    case (c)
      4'h0: begin
        chk("time_sec", time_sec, {win[2], win[1], win[0]});
        chk("time_ns", time_ns, {win[4][13:0], win[3]});
      end
      4'h1, 4'h2: begin
        chk("period_frac", period_frac, {win[4][7:0], win[3], win[2][15:8]});
        chk("period_ns", period_ns, win[4][15:8]);
        if (c == 4'h2) chk("tweak", tweak_duration, {win[2][7:0], win[1]});
      end
      4'h3, 4'h4: chk("pulse_cmd", pulse_cmd, {win[4][5:0], win[3]});
      default: begin
        chk("offset_frac", offset_frac, win[3][1:0]);
        chk("offset_ns", offset_ns, (c == 4'h8) ? {1'b0, win[4][14:0],
          win[3][15:2]} : {win[4], win[3][15:2]});
      end
    endcase
  endtask : check_store

  task check_fetch(input int src);
    logic [47:0] s;
    logic [29:0] n;
    logic hdr;
    int q;
    q = (src == 0) ? 0 : src - 1;
    s = (src == 0) ? now_sec : q_sec[q];
    n = (src == 0) ? now_ns : q_ns[q];
    hdr = (src == 2 && !two_ch) || (src == 3 && !three_ch);
    for (int i = 0; i < 3; i++) begin
      rd(ADDR_WIN1 + 4'(i), d);
      chk("window sec", d, s[16*i +: 16]);
    end
    rd(ADDR_WIN4, d);
    chk("window ns", d, n[15:0]);
    rd(ADDR_WIN5, d);
    chk("window five", d, {(src != 0) & q_edge[q], 1'b0, n[29:16]});
    rd(ADDR_HDR1, d);
    chk("header one", d, hdr ? {q_kind[q], q_hash[q]} : h1o);
    rd(ADDR_HDR2, d);
    chk("header two", d, hdr ? q_ord[q] : h2o);
  endtask : check_fetch

  function automatic logic [13:0] smask(input logic [3:0] c);
    return (c < 4'h5) ? 14'h1 << c : 14'h1 << (c - 4'h3);
  endfunction : smask

  // ====================================================================
  // Main sequence
  initial begin
    for (int q = 0; q < 3; q++) begin
      q_sec[q] = 48'h0;
      q_ns[q] = 30'h0;
      q_kind[q] = 4'h0;
      q_hash[q] = 12'h0;
      q_ord[q] = 16'h0;
    end
    void'($urandom(32'h4e6c9868));
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    for (int a = 7; a < 15; a++) begin
      rd(4'(a), d);
      chk("reset value", d, REG_RESET);
    end
    rd(4'h0, d);
    chk("unmapped", d, 16'h0000);
    $display("test reset done");
    repeat (4) begin
      rnd();
      load_win();
      for (int i = 0; i < 5; i++) begin
        rd(ADDR_WIN1 + 4'(i), d);
        chk("readback", d, win[i]);
      end
      cw = 16'($urandom()) & 16'h7f7f;
      wr(ADDR_CMD, cw);
      rd(ADDR_CMD, d);
      chk("command fields", d, cw & 16'h070f);
    end
    $display("test readback done");
    repeat (2) foreach (codes[k]) begin
      rnd();
      load_win();
      run(16'h0080 | 16'(codes[k]), smask(codes[k]));
      check_store(codes[k]);
    end
    $display("test stores done");
    q_ne = 3'h7;
    repeat (3) for (int src = 0; src < 4; src++) begin
      rnd();
      run(16'h8000 | (16'(src) << 8), (src == 0) ? 14'h0 : 14'h1 << (8 + src));
      check_fetch(src);
    end
    $display("test fetches done");
    rnd();
    load_win();
    run(16'h8080, 14'h1);
    check_store(4'h0);
    check_fetch(0);
    $display("test store then fetch done");
    summarize();
  end

  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule : tb
